// ==== src/srp_regs.sv ====
`timescale 1ns/10ps
`include "srp_cfg.svh"

module srp_regs
	import srp_pkg::*;
(
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// register port
	input  wire logic [7:0]   reg_addr,
	input  wire logic [15:0]  reg_wdata,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	output logic      [15:0]  reg_rdata,
	// device pins, asynchronous
	input  wire logic         powerdown_pin,
	input  wire logic         sync_pin,
	input  wire logic         frame_pin,
	input  wire logic         output_strobe,
	// on-chip controls, same clock
	input  wire logic         sif_sync_bit,
	input  wire logic [15:0]  sw_powerdown,
	input  wire srp_quad_type in_words,
	// results
	output srp_quad_type      conv_words,
	output logic              fifo_in_sync,
	output logic              fifo_out_sync,
	output logic              clkdiv_sync,
	output logic      [15:0]  block_powerdown
);

	// register state
	logic [15:0]  sync_q;
	logic [15:0]  route_q;
	logic [15:0]  pdmask_q;
	logic [15:0]  rdata_q;

	// pin synchronisers and edge history
	logic [3:0]   pin_s1_q;
	logic [3:0]   pin_s2_q;
	logic [3:0]   pin_s3_q;
	logic         sif_prev_q;

	// output flops
	srp_quad_type conv_q;
	logic         fin_sync_q;
	logic         fout_sync_q;
	logic         clkdiv_sync_q;
	logic [15:0]  pd_q;

	// decode of the register port, sync sources, power-down and routing
	wire logic         wr_sync;
	wire logic         wr_route;
	wire logic         wr_pdmask;
	wire logic [15:0]  rd_mux;
	wire logic [3:0]   pin_raw;
	wire logic [3:0]   pin_rise;
	wire logic [3:0]   src_evt;
	wire logic [3:0]   fin_sel;
	wire logic [3:0]   fout_sel;
	wire logic         clkdiv_sel;
	wire logic         fin_hit;
	wire logic         fout_hit;
	wire logic         clkdiv_hit;
	wire logic [15:0]  pin_req;
	wire logic [15:0]  pd_d;
	srp_quad_type      routed;

	srp_route_if rt ();

	assign wr_sync   = reg_wr && (reg_addr == `SRP_ADDR_SYNC);
	assign wr_route  = reg_wr && (reg_addr == `SRP_ADDR_ROUTE);
	assign wr_pdmask = reg_wr && (reg_addr == `SRP_ADDR_PDMASK);

	// reserved and unmapped offsets read zero; writes there are dropped
	assign rd_mux = (reg_addr == `SRP_ADDR_SYNC)   ? sync_q   :
	                (reg_addr == `SRP_ADDR_ROUTE)  ? route_q  :
	                (reg_addr == `SRP_ADDR_PDMASK) ? pdmask_q :
	                `SRP_RST_RSVD;

	// writable registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync_q   <= `SRP_RST_SYNC;
			route_q  <= `SRP_RST_ROUTE;
			pdmask_q <= `SRP_RST_PDMASK;
		end else begin
			if (wr_sync)
				sync_q <= reg_wdata & `SRP_SYNC_WMASK;
			if (wr_route)
				route_q <= reg_wdata;
			if (wr_pdmask)
				pdmask_q <= reg_wdata;
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			rdata_q <= 16'h0000;
		else
			rdata_q <= reg_rd ? rd_mux : 16'h0000;
	end

	// pins cross in through two flops; the third only serves edge detection
	assign pin_raw[`SRP_PIN_FRAME] = frame_pin;
	assign pin_raw[`SRP_PIN_OUTPUT_STROBE]  = output_strobe;
	assign pin_raw[`SRP_PIN_SYNC]  = sync_pin;
	assign pin_raw[`SRP_PIN_PD]    = powerdown_pin;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_s1_q   <= 4'h0;
			pin_s2_q   <= 4'h0;
			pin_s3_q   <= 4'h0;
			sif_prev_q <= 1'b0;
		end else begin
			pin_s1_q   <= pin_raw;
			pin_s2_q   <= pin_s1_q;
			pin_s3_q   <= pin_s2_q;
			sif_prev_q <= sif_sync_bit;
		end
	end

	assign pin_rise = pin_s2_q & ~pin_s3_q;

	// one event per source; software sync is the rising edge of its bit
	assign src_evt[`SRP_SRC_FRAME] = pin_rise[`SRP_PIN_FRAME];
	assign src_evt[`SRP_SRC_OUTPUT_STROBE]  = pin_rise[`SRP_PIN_OUTPUT_STROBE];
	assign src_evt[`SRP_SRC_SYNC]  = pin_rise[`SRP_PIN_SYNC];
	assign src_evt[`SRP_SRC_SIF]   = sif_sync_bit & ~sif_prev_q;

	// sync selection; any enabled source fires
	assign fin_sel    = sync_q[`SRP_FIN_HI:`SRP_FIN_LO];
	assign fout_sel   = sync_q[`SRP_FOUT_HI:`SRP_FOUT_LO];
	assign clkdiv_sel = sync_q[`SRP_CLKDIV_BIT];
	assign fin_hit    = |(fin_sel & src_evt);
	assign fout_hit   = |(fout_sel & src_evt);
	// divider follows the strobe, or the frame/sync sources chosen for input
	assign clkdiv_hit = clkdiv_sel ? |(fin_sel & src_evt & `SRP_FS_MASK)
	                               : src_evt[`SRP_SRC_OUTPUT_STROBE];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fin_sync_q    <= 1'b0;
			fout_sync_q   <= 1'b0;
			clkdiv_sync_q <= 1'b0;
		end else begin
			fin_sync_q    <= fin_hit;
			fout_sync_q   <= fout_hit;
			clkdiv_sync_q <= clkdiv_hit;
		end
	end

	// power-down: pin gated per block, ored with software; unused bits stay low
	assign pin_req = {16{pin_s2_q[`SRP_PIN_PD]}} & pdmask_q;
	assign pd_d    = (sw_powerdown | pin_req) & `SRP_PD_USED;

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			pd_q <= 16'h0000;
		else
			pd_q <= pd_d;
	end

	// routing mux lives in its own module; result is registered here
	assign rt.in_words  = in_words;
	assign rt.route_cfg = route_q;
	assign routed       = rt.out_words;

	srp_route_mux u_route (
		.rt (rt.mux)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			conv_q <= '0;
		else
			conv_q <= routed;
	end

	// outputs straight from flops
	assign reg_rdata       = rdata_q;
	assign conv_words      = conv_q;
	assign fifo_in_sync    = fin_sync_q;
	assign fifo_out_sync   = fout_sync_q;
	assign clkdiv_sync     = clkdiv_sync_q;
	assign block_powerdown = pd_q;

	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// fifo input sync fires exactly one cycle after an enabled event
	property p_fin_sync;
		(|(fin_sel & src_evt)) |=> fifo_in_sync;
	endproperty
	a_fin_sync: assert property (p_fin_sync) else $error("fifo input sync missed");

	// no enabled event means no input sync
	property p_fin_quiet;
		!(|(fin_sel & src_evt)) |=> !fifo_in_sync;
	endproperty
	a_fin_quiet: assert property (p_fin_quiet) else $error("spurious fifo input sync");

	// output side follows its own field, not the input field
	property p_fout_sync;
		fifo_out_sync == $past(|(fout_sel & src_evt));
	endproperty
	a_fout_sync: assert property (p_fout_sync) else $error("fifo output sync wrong");

	// divider on strobe while select bit is low
	property p_clkdiv_output_strobe;
		(!clkdiv_sel && pin_s2_q[`SRP_PIN_OUTPUT_STROBE] && !pin_s3_q[`SRP_PIN_OUTPUT_STROBE])
			|=> clkdiv_sync;
	endproperty
	a_clkdiv_output_strobe: assert property (p_clkdiv_output_strobe) else $error("divider sync on strobe missed");

	// divider ignores the strobe alone when select bit is high
	property p_clkdiv_fs;
		(clkdiv_sel && !(|(fin_sel & src_evt & `SRP_FS_MASK))) |=> !clkdiv_sync;
	endproperty
	a_clkdiv_fs: assert property (p_clkdiv_fs) else $error("divider sync from wrong source");

	// converter output A carries the word its path chain selects, one cycle on
	property p_route_a;
		conv_words[0] == $past(in_words[route_q[15 - 2*route_q[7:6] -: 2]]);
	endproperty
	a_route_a: assert property (p_route_a) else $error("output A routing wrong");

	// route register read back in the cycle after the strobe
	property p_route_read;
		(reg_rd && reg_addr == `SRP_ADDR_ROUTE) |=> reg_rdata == $past(route_q);
	endproperty
	a_route_read: assert property (p_route_read) else $error("route readback wrong");

	// a pin held high three cycles puts masked converter A to sleep
	property p_pin_sleep;
		(powerdown_pin && pdmask_q[`SRP_PD_CONV_A]
			&& !wr_pdmask)[*3] |=> block_powerdown[`SRP_PD_CONV_A];
	endproperty
	a_pin_sleep: assert property (p_pin_sleep) else $error("pin power-down missed");

	// cleared mask bit leaves the block to software alone
	property p_mask_off;
		!pdmask_q[`SRP_PD_PLL] |=> block_powerdown[`SRP_PD_PLL]
			== $past(sw_powerdown[`SRP_PD_PLL]);
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("masked pin reached block");

	// software power-down always wins through
	property p_sw_wins;
		sw_powerdown[`SRP_PD_BIAS] |=> block_powerdown[`SRP_PD_BIAS];
	endproperty
	a_sw_wins: assert property (p_sw_wins) else $error("software power-down overridden");

	// unused mask positions never sleep anything
	property p_unused;
		(block_powerdown & ~`SRP_PD_USED) == 16'h0000;
	endproperty
	a_unused: assert property (p_unused) else $error("unused power-down bit set");

	// reserved sync bits 7:1 can never be written
	property p_sync_rsvd;
		(sync_q & ~`SRP_SYNC_WMASK) == 16'h0000;
	endproperty
	a_sync_rsvd: assert property (p_sync_rsvd) else $error("reserved sync bits set");

	// read data falls back to zero when no read was asked for
	property p_rdata_idle;
		!reg_rd |=> reg_rdata == 16'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

	// a low pin with software quiet keeps converter A awake
	property p_pin_idle;
		!powerdown_pin ##2 !sw_powerdown[`SRP_PD_CONV_A]
			|=> !block_powerdown[`SRP_PD_CONV_A];
	endproperty
	a_pin_idle: assert property (p_pin_idle) else $error("block slept without request");

	// converter output D follows its own selector chain
	property p_route_d;
		conv_words[3] == $past(in_words[route_q[15 - 2*route_q[1:0] -: 2]]);
	endproperty
	a_route_d: assert property (p_route_d) else $error("output D routing wrong");

	// main scenarios
	c_multi_src: cover property ($countones(fin_sel) > 1 && fifo_in_sync);
	c_clkdiv_fs: cover property (clkdiv_sel && clkdiv_sync);
	c_pin_sleep: cover property (pin_s2_q[`SRP_PIN_PD] && block_powerdown[`SRP_PD_CLKRX]);
	c_swap:      cover property (route_q != `SRP_RST_ROUTE ##1 conv_words != $past(in_words));

endmodule

// ==== src/srp_cfg.svh ====
`ifndef SRP_CFG_SVH
`define SRP_CFG_SVH

// register offsets, as seen on the register port address
`define SRP_ADDR_SYNC       8'h20
`define SRP_ADDR_RSVD       8'h21
`define SRP_ADDR_ROUTE      8'h22
`define SRP_ADDR_PDMASK     8'h23

// reset values
`define SRP_RST_SYNC        16'h2400
`define SRP_RST_RSVD        16'h0000
`define SRP_RST_ROUTE       16'h1B1B
`define SRP_RST_PDMASK      16'hFFFF

// sync select field positions
`define SRP_FIN_HI          15
`define SRP_FIN_LO          12
`define SRP_FOUT_HI         11
`define SRP_FOUT_LO         8
`define SRP_CLKDIV_BIT      0

// writable bits of the sync select register; 7:1 are reserved and read zero
`define SRP_SYNC_WMASK      16'hFF01

// sync source bit positions inside each 4-bit select field
`define SRP_SRC_SIF         3
`define SRP_SRC_SYNC        2
`define SRP_SRC_OUTPUT_STROBE        1
`define SRP_SRC_FRAME       0

// frame and sync sources that may drive the divider sync
`define SRP_FS_MASK         4'h5

// power-down mask bit positions
`define SRP_PD_CONV_A       15
`define SRP_PD_CONV_D       12
`define SRP_PD_CLKRX        11
`define SRP_PD_PLL          10
`define SRP_PD_DATARX       9
`define SRP_PD_CTRLRX       8
`define SRP_PD_TEMP         7
`define SRP_PD_BIAS         5

// blocks that really exist behind the mask; bit 6 and 4:0 are unused
`define SRP_PD_USED         16'hFFA0

// pin synchroniser lane order
`define SRP_PIN_FRAME       0
`define SRP_PIN_OUTPUT_STROBE        1
`define SRP_PIN_SYNC        2
`define SRP_PIN_PD          3

`endif

// ==== src/srp_pkg.sv ====
package srp_pkg;

	// one sample word and a group of four of them
	typedef logic [15:0]      srp_word_type;
	typedef logic [3:0][15:0] srp_quad_type;

	// sync source index inside a select field
	typedef enum logic [1:0] {
		SRP_SRC_FRAME_E = 2'b00,
		SRP_SRC_OUTPUT_STROBE_E  = 2'b01,
		SRP_SRC_SYNC_E  = 2'b10,
		SRP_SRC_SIF_E   = 2'b11
	} srp_src_type;

endpackage

// ==== src/srp_route_if.sv ====
`timescale 1ns/10ps
interface srp_route_if;
	import srp_pkg::*;

	srp_quad_type in_words;
	logic [15:0]  route_cfg;
	srp_quad_type out_words;

	modport owner (output in_words, output route_cfg, input out_words);
	modport mux (input in_words, input route_cfg, output out_words);
endinterface

// ==== src/srp_route_mux.sv ====
`timescale 1ns/10ps
module srp_route_mux
	import srp_pkg::*;
(
	// routing words and selectors
	srp_route_if.mux rt
);

	wire srp_quad_type path_words;

	// word to path, then path to converter output; lane 0 is A
	for (genvar i = 0; i < 4; i++) begin : g_lane
		wire logic [1:0] path_pick;
		wire logic [1:0] out_pick;
		assign path_pick        = rt.route_cfg[15 - 2*i -: 2];
		assign out_pick         = rt.route_cfg[7 - 2*i -: 2];
		assign path_words[i]    = rt.in_words[path_pick];
		assign rt.out_words[i]  = path_words[out_pick];
	end

endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`include "srp_cfg.svh"
`define CHK(nm, ex, got) begin \
	num_checks++; \
	if ((got) !== (ex)) begin \
		err_count++; \
		$display("MISMATCH %s expected %h seen %h", nm, ex, got); \
	end \
end

module tb_top
	import srp_pkg::*;
;
	// design ports
	logic         clock;
	logic         rst;
	logic [7:0]   reg_addr;
	logic [15:0]  reg_wdata;
	logic         reg_wr;
	logic         reg_rd;
	logic [15:0]  reg_rdata;
	logic         pd_pin;
	logic [3:0]   src_q;
	logic [15:0]  sw_pd;
	srp_quad_type in_words;
	srp_quad_type conv_words;
	logic         fin_s;
	logic         fout_s;
	logic         clk_s;
	logic [15:0]  blk_pd;
	// bench state: register shadows and pulse counters
	logic [15:0]  sync_m;
	logic [15:0]  route_m;
	logic [15:0]  mask_m;
	logic [31:0]  cnt_i;
	logic [31:0]  cnt_o;
	logic [31:0]  cnt_c;
	integer       seed;
	int           err_count;
	int           num_checks;

	srp_regs i_srp_regs (
		.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.powerdown_pin(pd_pin), .sync_pin(src_q[2]), .frame_pin(src_q[0]),
		.output_strobe(src_q[1]), .sif_sync_bit(src_q[3]), .sw_powerdown(sw_pd),
		.in_words(in_words), .conv_words(conv_words), .fifo_in_sync(fin_s),
		.fifo_out_sync(fout_s), .clkdiv_sync(clk_s), .block_powerdown(blk_pd)
	);

	// 200 MHz clock
	always #2.5 clock = ~clock;

	// count sync pulses; x on an output poisons the count, so it cannot pass
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_i <= 32'h0; cnt_o <= 32'h0; cnt_c <= 32'h0;
		end else begin
			cnt_i <= cnt_i + 32'(fin_s); cnt_o <= cnt_o + 32'(fout_s); cnt_c <= cnt_c + 32'(clk_s);
		end
	end

	function automatic logic [15:0] exp_reg(input logic [7:0] a);
		case (a)
			`SRP_ADDR_SYNC:   return sync_m;
			`SRP_ADDR_ROUTE:  return route_m;
			`SRP_ADDR_PDMASK: return mask_m;
			default:          return 16'h0000;
		endcase
	endfunction

	// output j picks a path, the path picks an input word
	function automatic logic [15:0] exp_conv(input logic [15:0] c, input srp_quad_type w, int j);
		logic [1:0] o;
		o = c[7-2*j -: 2];
		return w[c[15-2*o -: 2]];
	endfunction

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		if (a == `SRP_ADDR_SYNC) sync_m = d & `SRP_SYNC_WMASK;
		if (a == `SRP_ADDR_ROUTE) route_m = d;
		if (a == `SRP_ADDR_PDMASK) mask_m = d;
	endtask

	// read data stands in the next cycle only, then returns to zero
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_rd <= 1'b1; reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 `CHK("reg_rdata", exp_reg(a), reg_rdata)
		@(posedge clock);
		#1 `CHK("reg_rdata idle", 16'h0000, reg_rdata)
	endtask

	// one rising edge on source s, then count what each sync output did
	task automatic fire(input int s);
		logic [31:0] a, b, c;
		logic        ec;
		a = cnt_i; b = cnt_o; c = cnt_c;
		@(posedge clock);
		src_q[s] <= 1'b1;
		repeat (2) @(posedge clock);
		src_q[s] <= 1'b0;
		repeat (6) @(posedge clock);
		#1 ec = sync_m[0] ? (sync_m[12+s] && (s == 0 || s == 2)) : (s == 1);
		`CHK("fifo_in_sync", a + sync_m[12+s], cnt_i)
		`CHK("fifo_out_sync", b + sync_m[8+s], cnt_o)
		`CHK("clkdiv_sync", c + ec, cnt_c)
	endtask

	// watchdog sized well past the expected run of under a thousand cycles
	initial begin
		#100000;
		err_count++;
		close_out();
	end

	// main sequence; reset raised by nba so every flop is waiting for its edge
	initial begin
		clock = 1'b0; rst <= 1'b1; reg_addr = 8'h00; reg_wdata = 16'h0000;
		reg_wr = 1'b0; reg_rd = 1'b0; pd_pin = 1'b0; src_q = 4'h0;
		sw_pd = 16'h0000; in_words = '0; err_count = 0; num_checks = 0;
		seed = 32'h1157;
		sync_m = `SRP_RST_SYNC; route_m = `SRP_RST_ROUTE; mask_m = `SRP_RST_PDMASK;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		for (int a = 8'h20; a <= 8'h24; a++) rd(8'(a));
		for (int s = 0; s < 4; s++) fire(s);
		// all sources, none, then random selections
		for (int k = 0; k < 6; k++) begin
			wr(`SRP_ADDR_SYNC, k == 0 ? 16'hFFFF : k == 1 ? 16'h0000 : 16'($random(seed)));
			rd(`SRP_ADDR_SYNC);
			for (int s = 0; s < 4; s++) fire(s);
		end
		// routing and power-down with random words, masks and pin levels
		for (int i = 0; i < 24; i++) begin
			wr(`SRP_ADDR_RSVD, 16'($random(seed)));
			wr(`SRP_ADDR_ROUTE, 16'($random(seed)));
			wr(`SRP_ADDR_PDMASK, i == 0 ? 16'h0000 : 16'($random(seed)));
			for (int a = 8'h20; a <= 8'h24; a++) rd(8'(a));
			@(posedge clock);
			in_words <= {$random(seed), $random(seed)};
			pd_pin <= (i == 0) ? 1'b1 : 1'($random(seed));
			sw_pd <= (i == 1) ? 16'hFFFF : 16'($random(seed));
			repeat (5) @(posedge clock);
			#1;
			for (int j = 0; j < 4; j++)
				`CHK("conv_words", exp_conv(route_m, in_words, j), conv_words[j])
			`CHK("block_powerdown", (sw_pd | (pd_pin ? mask_m : 16'h0)) & 16'hFFA0, blk_pd)
		end
		close_out();
	end
endmodule
